// File: aao_pkg.sv
// Package: shared types and constants for the add and AND datapath
package aao_pkg;

    localparam int DATA_W = 8;
    localparam int NIB_W  = 4;
    localparam int MSB    = 7;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [7:0] ZERO_B   = 8'h00;
    localparam logic [7:0] MEM_RST  = 8'h00;

    // Operations handed over by the instruction decoder
    typedef enum logic [2:0] {
        AAO_OP_NONE,
        AAO_OP_ADD_TO_MEM,
        AAO_OP_AND_MEM_TO_W,
        AAO_OP_AND_IMM_TO_W,
        AAO_OP_AND_INTO_MEM,
        // Loads the working register from the immediate byte
        AAO_OP_LOAD_W
    } aao_op_t;

    // Request from decoder
    typedef struct packed {
        aao_op_t    op;
        logic [7:0] imm;
    } aao_req_t;

    // Status flags
    typedef struct packed {
        logic range_flag;
        logic null_flag;
        logic nibble_flag;
        logic carry_flag;
    } aao_flags_t;

    // Memory write-back
    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } aao_wb_t;

endpackage : aao_pkg

// File: aao_calc.sv
// Combinational arithmetic and logic core of the add and AND datapath
`timescale 1ns/100ps
module aao_calc #(
    parameter int W = aao_pkg::DATA_W
) (
    input  wire logic [W-1:0] i_a,
    input  wire logic [W-1:0] i_b,
    output logic      [W-1:0] o_sum,
    output logic      [W-1:0] o_and,
    output logic              o_carry,
    output logic              o_nibble,
    output logic              o_range
);
    wire logic [W:0]             full_sum;
    wire logic [aao_pkg::NIB_W:0] low_sum;

    assign full_sum = {1'b0, i_a} + {1'b0, i_b};
    assign low_sum  = {1'b0, i_a[aao_pkg::NIB_W-1:0]} + {1'b0, i_b[aao_pkg::NIB_W-1:0]};
    assign o_sum    = full_sum[W-1:0];
    assign o_carry  = full_sum[W];
    assign o_nibble = low_sum[aao_pkg::NIB_W];
    // Signed overflow: like-signed operands giving an unlike-signed sum
    assign o_range  = (i_a[W-1] == i_b[W-1]) && (o_sum[W-1] != i_a[W-1]);
    assign o_and    = i_a & i_b;
endmodule // aao_calc

// File: aao_alu.sv
// Add and AND datapath: working register, flags and data memory write-back
`timescale 1ns/100ps
module aao_alu #(
    parameter int W = aao_pkg::DATA_W
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire aao_pkg::aao_req_t    i_req,
    input  wire logic [W-1:0]         i_mem_rdata,
    output aao_pkg::aao_wb_t          o_mem_wb,
    output logic [W-1:0]              o_working_register,
    output aao_pkg::aao_flags_t       o_flags
);
    // ------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------
    logic [W-1:0]         working_register;
    aao_pkg::aao_flags_t  flags;
    aao_pkg::aao_wb_t     mem_wb;

    wire logic [W-1:0] sum_res;
    wire logic [W-1:0] and_mem_res;
    wire logic [W-1:0] and_imm_res;
    wire logic         add_c;
    wire logic         add_ac;
    wire logic         add_ov;
    // Operation decode, one strobe per instruction
    wire logic         is_add;
    wire logic         is_and_m;
    wire logic         is_and_i;
    wire logic         is_and_into;
    wire logic         is_load;

    assign is_add      = i_req.op == aao_pkg::AAO_OP_ADD_TO_MEM;
    assign is_and_m    = i_req.op == aao_pkg::AAO_OP_AND_MEM_TO_W;
    assign is_and_i    = i_req.op == aao_pkg::AAO_OP_AND_IMM_TO_W;
    assign is_and_into = i_req.op == aao_pkg::AAO_OP_AND_INTO_MEM;
    assign is_load     = i_req.op == aao_pkg::AAO_OP_LOAD_W;

    // Adder and AND share the working register as first operand
    aao_calc #(.W(W)) u_calc (
        .i_a      (working_register),
        .i_b      (i_mem_rdata),
        .o_sum    (sum_res),
        .o_and    (and_mem_res),
        .o_carry  (add_c),
        .o_nibble (add_ac),
        .o_range  (add_ov)
    );
    assign and_imm_res = working_register & i_req.imm;

    // Result-null test, shared by every operation that can touch that flag
    function automatic logic is_null(input logic [W-1:0] value);
        return value == aao_pkg::ZERO_B;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    wire logic [W-1:0]        next_working_register;
    wire aao_pkg::aao_flags_t next_flags;
    wire aao_pkg::aao_wb_t    next_mem_wb;

    // The load stands in for the core's move path, so the register can leave zero
    assign next_working_register = is_and_m ? and_mem_res :
                                   is_and_i ? and_imm_res :
                                   is_load  ? i_req.imm   :
                                   working_register;
    assign next_flags.range_flag  = is_add ? add_ov : flags.range_flag;
    assign next_flags.nibble_flag = is_add ? add_ac : flags.nibble_flag;
    assign next_flags.carry_flag  = is_add ? add_c  : flags.carry_flag;
    assign next_flags.null_flag   = is_add      ? is_null(sum_res) :
                                    is_and_m    ? is_null(and_mem_res) :
                                    is_and_i    ? is_null(and_imm_res) :
                                    is_and_into ? is_null(and_mem_res) :
                                    flags.null_flag;
    assign next_mem_wb.we   = is_add || is_and_into;
    assign next_mem_wb.data = is_add ? sum_res :
                              is_and_into ? and_mem_res :
                              aao_pkg::MEM_RST;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Async clear puts every output at its reset value
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            working_register <= aao_pkg::WORK_RST;
            flags            <= '0;
            mem_wb           <= '0;
        end
        else
        begin
            working_register <= next_working_register;
            flags            <= next_flags;
            mem_wb           <= next_mem_wb;
        end
    end

    // Outputs come straight from the flip-flops
    assign o_working_register = working_register;
    assign o_flags            = flags;
    assign o_mem_wb           = mem_wb;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence add_req_s;
        i_req.op == aao_pkg::AAO_OP_ADD_TO_MEM;
    endsequence

    sequence and_mem_req_s;
        i_req.op == aao_pkg::AAO_OP_AND_MEM_TO_W;
    endsequence

    sequence and_imm_req_s;
        i_req.op == aao_pkg::AAO_OP_AND_IMM_TO_W;
    endsequence

    sequence and_into_req_s;
        i_req.op == aao_pkg::AAO_OP_AND_INTO_MEM;
    endsequence

    sequence load_req_s;
        i_req.op == aao_pkg::AAO_OP_LOAD_W;
    endsequence

    // Any code that names no operation, the spare codes included
    sequence idle_req_s;
        !(is_add || is_and_m || is_and_i || is_and_into || is_load);
    endsequence

    add_wb_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        add_req_s |=> mem_wb.we && mem_wb.data == $past(working_register) + $past(i_mem_rdata))
        else $error("add result not written back");

    add_carry_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        add_req_s |=> flags.carry_flag == ({1'b0, $past(working_register)} + {1'b0, $past(i_mem_rdata)} > 9'h0FF))
        else $error("add carry wrong");

    add_keep_w_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        add_req_s |=> $stable(working_register))
        else $error("add changed working register");

    and_mem_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        is_and_m |=> working_register == ($past(working_register) & $past(i_mem_rdata)) && !mem_wb.we)
        else $error("and memory result wrong");

    and_imm_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        is_and_i |=> working_register == ($past(working_register) & $past(i_req.imm))
                     && flags.null_flag == (working_register == aao_pkg::ZERO_B))
        else $error("and immediate result wrong");

    and_flags_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (is_and_m || is_and_i) |=> $stable(flags.carry_flag) && $stable(flags.range_flag)
                                   && $stable(flags.nibble_flag))
        else $error("and changed other flags");

    and_into_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        is_and_into |=> mem_wb.we && mem_wb.data == ($past(working_register) & $past(i_mem_rdata)))
        else $error("and into memory data wrong");

    and_into_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        is_and_into |=> $stable(working_register) && flags.null_flag == (mem_wb.data == aao_pkg::ZERO_B))
        else $error("and into memory side effects wrong");

    // ------------------------------------------------------------
    // Flag, load, write-back, idle and reset checks
    // ------------------------------------------------------------
    // Add flags are rebuilt from the operands and the written-back sum, not taken from the adder's flag outputs
    add_range_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        add_req_s |=> flags.range_flag == ($past(working_register[W-1]) == $past(i_mem_rdata[W-1])
                                           && mem_wb.data[W-1] != $past(i_mem_rdata[W-1])))
        else $error("add range flag wrong");

    add_nibble_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        add_req_s |=> flags.nibble_flag == (({1'b0, $past(working_register[aao_pkg::NIB_W-1:0])}
                                            + {1'b0, $past(i_mem_rdata[aao_pkg::NIB_W-1:0])}) > 5'h0F))
        else $error("add nibble flag wrong");

    add_null_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        add_req_s |=> flags.null_flag == (mem_wb.data == aao_pkg::ZERO_B))
        else $error("add null flag wrong");

    and_mem_null_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        and_mem_req_s |=> flags.null_flag == (working_register == aao_pkg::ZERO_B))
        else $error("and memory null flag wrong");

    and_imm_wb_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        and_imm_req_s |=> !mem_wb.we)
        else $error("and immediate wrote memory");

    and_into_flags_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        and_into_req_s |=> $stable(flags.carry_flag) && $stable(flags.range_flag)
                           && $stable(flags.nibble_flag))
        else $error("and into memory changed other flags");

    load_w_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        load_req_s |=> working_register == $past(i_req.imm) && $stable(flags) && !mem_wb.we)
        else $error("load of working register wrong");

    idle_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        idle_req_s |=> $stable(working_register) && $stable(flags) && !mem_wb.we)
        else $error("idle cycle changed state");

    // The write-back strobe stands one cycle unless another write follows
    wb_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        mem_wb.we && !(is_add || is_and_into) |=> !mem_wb.we)
        else $error("write-back strobe stood too long");

    wb_idle_data_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !mem_wb.we |-> mem_wb.data == aao_pkg::MEM_RST)
        else $error("write-back data not cleared");

    // Sampled one edge after reset is seen, so the asynchronous clear has settled
    reset_clear_a: assert property (@(posedge i_sys_clk)
        i_rst |=> working_register == aao_pkg::WORK_RST && flags == '0 && !mem_wb.we)
        else $error("reset did not clear the outputs");

endmodule // aao_alu

// File: aao_mem_model.sv
// Partner model: small data memory feeding the add and AND datapath
`timescale 1ns/100ps
module aao_mem_model (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic [3:0]       i_addr,
    input  wire aao_pkg::aao_wb_t i_wb,
    output logic      [7:0]       o_rdata
);
    logic [7:0] mem [16];
    logic [3:0] wb_addr;
    // Write-back lands one cycle late, so a read of the same byte is bypassed
    assign o_rdata = (i_wb.we && wb_addr == i_addr) ? i_wb.data : mem[i_addr];
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < 16; i++)
                mem[i] <= 8'(i * 8'h1F);
            wb_addr <= 4'h0;
        end
        else
        begin
            wb_addr <= i_addr;
            if (i_wb.we)
                mem[wb_addr] <= i_wb.data;
        end
    end
endmodule // aao_mem_model

// File: alu_add_and_ops_bench.sv
// Testbench: random add and AND traffic checked against queued expectations
`timescale 1ns/100ps
module alu_add_and_ops_bench;
    logic                i_sys_clk    = 1'b0;
    logic                i_rst        = 1'b1;
    aao_pkg::aao_req_t   req          = '0;
    logic [3:0]          addr         = 4'h0;
    logic [7:0]          rdata;
    aao_pkg::aao_wb_t    wb;
    logic [7:0]          w_reg;
    aao_pkg::aao_flags_t flags;
    logic [20:0]         exp_q [$];
    logic [20:0]         got;
    logic [20:0]         exp_v;
    logic [7:0]          sh [16];
    logic [7:0]          ew           = 8'h00;
    aao_pkg::aao_flags_t ef           = '0;
    int                  num_errors   = 0;
    int                  total_checks = 0;
    int                  cycles       = 0;
    int                  seed         = 32'h7842;

    always #50 i_sys_clk = ~i_sys_clk;

    aao_alu dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(req), .i_mem_rdata(rdata),
                   .o_mem_wb(wb), .o_working_register(w_reg), .o_flags(flags));
    aao_mem_model mem_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(addr), .i_wb(wb), .o_rdata(rdata));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Drive one op and note what the outputs must show one cycle later
    task automatic do_op(input aao_pkg::aao_op_t op, input logic [7:0] imm, input logic [3:0] a);
        logic [8:0]       s;
        logic [7:0]       m;
        aao_pkg::aao_wb_t ewb;
        #1;
        req.op = op;
        req.imm = imm;
        addr = a;
        m = sh[a];
        s = {1'b0, ew} + {1'b0, m};
        ewb = '0;
        case (op)
            aao_pkg::AAO_OP_ADD_TO_MEM:
            begin
                ewb = {1'b1, s[7:0]};
                ef = {(ew[7] == m[7]) && (s[7] != m[7]), s[7:0] == 8'h00,
                      ({1'b0, ew[3:0]} + {1'b0, m[3:0]}) > 5'h0F, s[8]};
                sh[a] = s[7:0];
            end
            aao_pkg::AAO_OP_AND_MEM_TO_W, aao_pkg::AAO_OP_AND_IMM_TO_W:
            begin
                ew = ew & ((op == aao_pkg::AAO_OP_AND_IMM_TO_W) ? imm : m);
                ef.null_flag = (ew == 8'h00);
            end
            aao_pkg::AAO_OP_AND_INTO_MEM:
            begin
                ewb = {1'b1, ew & m};
                ef.null_flag = ((ew & m) == 8'h00);
                sh[a] = ew & m;
            end
            aao_pkg::AAO_OP_LOAD_W:
                ew = imm;
            default: ;
        endcase
        @(posedge i_sys_clk);
        exp_q.push_back({ewb, ew, ef});
    endtask

    // Monitor: each cycle with a note pending, compare settled outputs
    always @(posedge i_sys_clk)
    begin
        #2;
        if (exp_q.size() > 0)
        begin
            got = {wb, w_reg, flags};
            exp_v = exp_q.pop_front();
            total_checks++;
            if (got !== exp_v)
            begin
                num_errors++;
                $display("mismatch outputs expected %h seen %h", exp_v, got);
            end
        end
    end

    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        for (int i = 0; i < 16; i++)
            sh[i] = 8'(i * 8'h1F);
        repeat (20) @(posedge i_sys_clk);
        #1;
        i_rst = 1'b0;
        @(posedge i_sys_clk);
        do_op(aao_pkg::AAO_OP_LOAD_W, 8'hFF, 4'h1);
        for (int i = 0; i < 5; i++)
            do_op(aao_pkg::aao_op_t'(i), 8'hFF, 4'h1);
        for (int n = 0; n < 400; n++)
            do_op(aao_pkg::aao_op_t'(($random(seed) & 32'h7FFF) % 6),
                  8'($random(seed)), 4'($random(seed)));
        // Mid-run reset: outputs, memory and shadow state return to reset values
        @(posedge i_sys_clk);
        #1;
        i_rst = 1'b1;
        req   = '0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_rst = 1'b0;
        for (int i = 0; i < 16; i++)
            sh[i] = 8'(i * 8'h1F);
        ew = aao_pkg::WORK_RST;
        ef = '0;
        @(posedge i_sys_clk);
        for (int i = 0; i < 6; i++)
            do_op(aao_pkg::aao_op_t'(i), 8'h5A, 4'h3);
        repeat (3) @(posedge i_sys_clk);
        report_and_stop();
    end
endmodule // alu_add_and_ops_bench
